/* File: verilog/dsc_dpll_ctrl.sv */
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module dsc_dpll_ctrl #(
  parameter int NREF        = 4,
  parameter int GPIO_W      = 4,
  parameter int CAL_CYC     = dsc_pkg::CAL_CYCLES,
  parameter int ACQ_CYC     = dsc_pkg::ACQ_CYCLES,
  parameter int HIST_CYC    = dsc_pkg::HIST_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Reference and loop monitors
  input  wire logic              xo_valid_i,
  input  wire logic [NREF-1:0]   ref_valid_i,
  input  wire logic              freq_lock_i,
  input  wire logic              phase_lock_i,
  input  wire logic [39:0]       hist_avg_i,
  // Step pins
  input  wire logic [GPIO_W-1:0] gpio_i,
  // Loop outputs
  output logic [39:0]            dpll_num_o,
  output logic [39:0]            apll_num_o,
  output logic [40:0]            den_eff_o,
  output logic                   wide_bw_o,
  output logic                   ref_qual_en_o,
  output logic                   hist_accum_o,
  output logic                   vco_cal_o,
  output logic                   freq_lock_lost_o,
  output logic                   phase_lock_lost_o
);

  typedef struct packed {
    dsc_pkg::dsc_state_t st;
    logic [15:0] cnt;
    logic        hist_en;
    logic        dco_en;
    logic        pin_mode;
    logic [1:0]  trig_sel;
    logic [1:0]  dir_sel;
    logic [37:0] step;
    logic [39:0] ofs;
    logic [39:0] num;
    logic [39:0] den;
    logic [39:0] dev;
    logic [39:0] apll_dev;
    logic        flost;
    logic        plost;
    logic        hist_valid;
    logic [15:0] hcnt;
    logic        trig_q;
    logic        ack;
    logic [31:0] dat;
    logic [39:0] dnum;
    logic [39:0] anum;
    logic [40:0] deff;
    logic        wide;
    logic        qual;
    logic        haccum;
    logic        cal;
  } dsc_regs_t;

  dsc_regs_t r_r;
  dsc_regs_t r_nxt;

  // Apply one signed step to an offset
  function automatic logic [39:0] step_apply(input logic [39:0] v,
                                             input logic [37:0] s,
                                             input logic        down);
    logic [39:0] e;
    e = {2'b00, s};
    step_apply = down ? v - e : v + e;
  endfunction

  // Byte-lane merge for 32-bit writes
  function automatic logic [31:0] lane(input logic [31:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lane = (old & ~m) | (d & m);
  endfunction

  logic        any_ref;
  logic        wr;
  logic        rd_req;
  logic        locked;
  logic        trig_now;
  logic        dir_now;
  logic [31:0] w;

  // Next-state logic for the whole channel
  always_comb begin
    r_nxt     = r_r;
    any_ref   = |ref_valid_i;
    wr        = wb_cyc_i && wb_stb_i && wb_we_i && !r_r.ack;
    rd_req    = wb_cyc_i && wb_stb_i && !r_r.ack;
    locked    = (r_r.st == dsc_pkg::DSC_ST_LOCKED);
    trig_now  = gpio_i[r_r.trig_sel];
    dir_now   = gpio_i[r_r.dir_sel];
    w         = 32'h0000_0000;
    r_nxt.ack = rd_req;
    r_nxt.trig_q = trig_now;

    // Operating state machine
    case (r_r.st)
      dsc_pkg::DSC_ST_CAL: begin
        r_nxt.cnt = xo_valid_i ? r_r.cnt + 16'h0001 : 16'h0000;
        if (xo_valid_i && int'(r_r.cnt) >= CAL_CYC - 1) begin
          r_nxt.st  = dsc_pkg::DSC_ST_FREERUN;
          r_nxt.cnt = 16'h0000;
        end
      end
      dsc_pkg::DSC_ST_FREERUN: begin
        if (any_ref) begin
          r_nxt.st  = dsc_pkg::DSC_ST_ACQ;
          r_nxt.cnt = 16'h0000;
        end
      end
      dsc_pkg::DSC_ST_ACQ: begin
        r_nxt.cnt = r_r.cnt + 16'h0001;
        if (!any_ref) begin
          r_nxt.st = dsc_pkg::DSC_ST_FREERUN;
        end else if (int'(r_r.cnt) >= ACQ_CYC - 1 && freq_lock_i) begin
          r_nxt.st = dsc_pkg::DSC_ST_LOCKED;
        end
      end
      dsc_pkg::DSC_ST_LOCKED: begin
        if (!any_ref) begin
          // No history yet means free-run, not holdover
          r_nxt.st = r_r.hist_valid ? dsc_pkg::DSC_ST_HOLD
                                    : dsc_pkg::DSC_ST_FREERUN;
          if (r_r.hist_valid) begin
            r_nxt.plost = 1'b1;
          end
        end
      end
      dsc_pkg::DSC_ST_HOLD: begin
        if (any_ref) begin
          r_nxt.st  = dsc_pkg::DSC_ST_ACQ;
          r_nxt.cnt = 16'h0000;
        end
      end
      default: begin
        r_nxt.st = dsc_pkg::DSC_ST_CAL;
      end
    endcase

    // Lock-lost flags frozen from the holdover entry edge on; the
    // detector may drop in the same cycle as the reference
    if (r_r.st != dsc_pkg::DSC_ST_HOLD
        && !(locked && !any_ref && r_r.hist_valid)) begin
      r_nxt.flost = !freq_lock_i;
      r_nxt.plost = !phase_lock_i;
    end

    // History averaging window after frequency lock
    if (r_r.hist_en && !r_r.flost && locked) begin
      if (int'(r_r.hcnt) >= HIST_CYC - 1) begin
        r_nxt.hist_valid = 1'b1;
      end else begin
        r_nxt.hcnt = r_r.hcnt + 16'h0001;
      end
    end else if (r_r.st == dsc_pkg::DSC_ST_FREERUN || !r_r.hist_en) begin
      r_nxt.hcnt       = 16'h0000;
      r_nxt.hist_valid = 1'b0;
    end

    // Oscillator steering, only while locked
    if (!r_r.dco_en || !locked) begin
      r_nxt.dev = 40'h00_0000_0000;
    end else if (r_r.pin_mode && trig_now && !r_r.trig_q) begin
      r_nxt.dev = step_apply(r_r.dev, r_r.step, dir_now);
    end

    // Register writes
    if (wr) begin
      case (wb_adr_i)
        dsc_pkg::DSC_CTRL: begin
          w = lane({28'h000_0000, 1'b0, r_r.pin_mode, r_r.dco_en,
                    r_r.hist_en}, wb_dat_i, wb_sel_i);
          r_nxt.hist_en  = w[dsc_pkg::CTL_HIST_EN];
          r_nxt.dco_en   = w[dsc_pkg::CTL_DCO_EN] && locked;
          r_nxt.pin_mode = w[dsc_pkg::CTL_PIN_MODE];
          if (w[dsc_pkg::CTL_SOFT_RST]) begin
            r_nxt.st         = dsc_pkg::DSC_ST_CAL;
            r_nxt.cnt        = 16'h0000;
            r_nxt.dco_en     = 1'b0;
            r_nxt.hist_valid = 1'b0;
            r_nxt.hcnt       = 16'h0000;
          end
        end
        dsc_pkg::DSC_STEP_CTL: begin
          r_nxt.trig_sel = wb_dat_i[dsc_pkg::STP_TRIG_SEL +: 2];
          r_nxt.dir_sel  = wb_dat_i[dsc_pkg::STP_DIR_SEL +: 2];
          if (wb_sel_i[0] && r_r.dco_en && locked) begin
            r_nxt.dev = step_apply(r_r.dev, r_r.step,
                                   wb_dat_i[dsc_pkg::STP_SOFT_BIT]);
          end
        end
        dsc_pkg::DSC_STEP_LO: r_nxt.step[31:0] =
          lane(r_r.step[31:0], wb_dat_i, wb_sel_i);
        dsc_pkg::DSC_STEP_HI: if (wb_sel_i[0]) begin
          r_nxt.step[37:32] = wb_dat_i[5:0];
        end
        dsc_pkg::DSC_OFS_LO: r_nxt.ofs[31:0] =
          lane(r_r.ofs[31:0], wb_dat_i, wb_sel_i);
        dsc_pkg::DSC_OFS_HI: if (wb_sel_i[0]) begin
          r_nxt.ofs[39:32] = wb_dat_i[7:0];
        end
        dsc_pkg::DSC_NUM_LO: r_nxt.num[31:0] =
          lane(r_r.num[31:0], wb_dat_i, wb_sel_i);
        dsc_pkg::DSC_NUM_HI: if (wb_sel_i[0]) begin
          r_nxt.num[39:32] = wb_dat_i[7:0];
        end
        dsc_pkg::DSC_DEN_LO: r_nxt.den[31:0] =
          lane(r_r.den[31:0], wb_dat_i, wb_sel_i);
        dsc_pkg::DSC_DEN_HI: if (wb_sel_i[0]) begin
          r_nxt.den[39:32] = wb_dat_i[7:0];
        end
        default: begin
        end
      endcase
    end

    // Analog offset in holdover and free-run only: history or offset word
    if (r_r.st == dsc_pkg::DSC_ST_HOLD) begin
      r_nxt.apll_dev = (r_r.hist_en && r_r.hist_valid) ? hist_avg_i
                                                       : r_r.ofs;
    end else if (r_r.st == dsc_pkg::DSC_ST_FREERUN) begin
      r_nxt.apll_dev = r_r.ofs;
    end else begin
      r_nxt.apll_dev = 40'h00_0000_0000;
    end

    // Registered outputs
    r_nxt.dnum   = r_r.num + (locked ? r_r.dev : 40'h00_0000_0000);
    r_nxt.anum   = r_r.num + r_r.apll_dev;
    r_nxt.deff   = (r_r.den == 40'h00_0000_0000) ? dsc_pkg::DEN_FULL
                                                 : {1'b0, r_r.den};
    r_nxt.wide   = (r_nxt.st == dsc_pkg::DSC_ST_ACQ);
    r_nxt.qual   = (r_nxt.st != dsc_pkg::DSC_ST_FREERUN)
                && (r_nxt.st != dsc_pkg::DSC_ST_CAL);
    r_nxt.haccum = r_nxt.hist_en && !r_nxt.flost
                && (r_nxt.st == dsc_pkg::DSC_ST_LOCKED);
    r_nxt.cal    = (r_nxt.st == dsc_pkg::DSC_ST_CAL);

    // Read mux
    r_nxt.dat = 32'h0000_0000;
    if (rd_req && !wb_we_i) begin
      case (wb_adr_i)
        dsc_pkg::DSC_CTRL: r_nxt.dat = {29'h0000_0000, r_r.pin_mode,
                                        r_r.dco_en, r_r.hist_en};
        dsc_pkg::DSC_STEP_CTL: r_nxt.dat = {24'h00_0000, r_r.dir_sel,
                                            r_r.trig_sel, 4'h0};
        dsc_pkg::DSC_STEP_LO: r_nxt.dat = r_r.step[31:0];
        dsc_pkg::DSC_STEP_HI: r_nxt.dat = {26'h000_0000, r_r.step[37:32]};
        dsc_pkg::DSC_OFS_LO:  r_nxt.dat = r_r.ofs[31:0];
        dsc_pkg::DSC_OFS_HI:  r_nxt.dat = {24'h00_0000, r_r.ofs[39:32]};
        dsc_pkg::DSC_NUM_LO:  r_nxt.dat = r_r.num[31:0];
        dsc_pkg::DSC_NUM_HI:  r_nxt.dat = {24'h00_0000, r_r.num[39:32]};
        dsc_pkg::DSC_DEN_LO:  r_nxt.dat = r_r.den[31:0];
        dsc_pkg::DSC_DEN_HI:  r_nxt.dat = {24'h00_0000, r_r.den[39:32]};
        dsc_pkg::DSC_STATUS:  r_nxt.dat = {19'h0_0000, r_r.st, r_r.cal,
          r_r.haccum, r_r.hist_valid, r_r.qual, r_r.wide, r_r.plost,
          r_r.flost, xo_valid_i};
        dsc_pkg::DSC_EFF_LO:  r_nxt.dat = r_r.dnum[31:0];
        dsc_pkg::DSC_EFF_HI:  r_nxt.dat = {24'h00_0000, r_r.dnum[39:32]};
        dsc_pkg::DSC_APLL_LO: r_nxt.dat = r_r.anum[31:0];
        dsc_pkg::DSC_APLL_HI: r_nxt.dat = {24'h00_0000, r_r.anum[39:32]};
        default: r_nxt.dat = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_r       <= '0;
      r_r.st    <= dsc_pkg::DSC_ST_CAL;
      r_r.flost <= 1'b1;
      r_r.plost <= 1'b1;
      r_r.cal   <= 1'b1;
      r_r.deff  <= dsc_pkg::DEN_FULL;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o          = r_r.ack;
  assign wb_dat_o          = r_r.dat;
  assign dpll_num_o        = r_r.dnum;
  assign apll_num_o        = r_r.anum;
  assign den_eff_o         = r_r.deff;
  assign wide_bw_o         = r_r.wide;
  assign ref_qual_en_o     = r_r.qual;
  assign hist_accum_o      = r_r.haccum;
  assign vco_cal_o         = r_r.cal;
  assign freq_lock_lost_o  = r_r.flost;
  assign phase_lock_lost_o = r_r.plost;

endmodule

/* File: pkg/dsc_pkg.sv */
// Functional notes
// - After configuration enter free-run; lock analog loop once crystal reference is valid.
// - In free-run every reference input is reported unqualified.
// - Reference lost after lock without valid history returns to free-run.
// - Any qualified input leaves free-run or holdover and starts acquisition.
// - Wide loop bandwidth during acquisition, normal bandwidth restored after.
// - Frequency and phase lock-lost flags readable as status bits and pins.
// - History accumulates once frequency lock-lost flag falls, if history enabled; the code accumulates only while in the locked state.
// - Reference loss with no valid input enters holdover; the code enters it only from lock with valid history, else free-run.
// - Holdover without history uses signed 40-bit offset word plus numerator.
// - Holdover with history uses valid average, else the offset word.
// - Entering holdover sets phase-lock-lost flag.
// - Frequency-lock-lost flag frozen in holdover until reference selected again.
// - Valid input during holdover leaves holdover toward lock without glitch.
// - Soft resets rerun start-up including oscillator calibration.
// - Steering alters feedback numerator when closed loop, else analog numerator; the code steers only the feedback numerator, and only while locked.
// - Oscillator steering enabled only while locked, by software enable bit.
// - Each step adds or subtracts the 38-bit step word.
// - Soft step bit write 0 increments, write 1 decrements.
// - Step pin rising edge applies one step; direction pin 0 up, 1 down.
// - Clearing the enable discards offset, restoring original numerator.
// - Relative steering by 8-bit control write; absolute by numerator write.
// - Denominator value zero means two to the 40th.
package dsc_pkg;
  // Register byte offsets
  localparam logic [7:0] DSC_CTRL      = 8'h00;
  localparam logic [7:0] DSC_STEP_CTL  = 8'h04;
  localparam logic [7:0] DSC_STEP_LO   = 8'h08;
  localparam logic [7:0] DSC_STEP_HI   = 8'h0C;
  localparam logic [7:0] DSC_OFS_LO    = 8'h10;
  localparam logic [7:0] DSC_OFS_HI    = 8'h14;
  localparam logic [7:0] DSC_NUM_LO    = 8'h18;
  localparam logic [7:0] DSC_NUM_HI    = 8'h1C;
  localparam logic [7:0] DSC_DEN_LO    = 8'h20;
  localparam logic [7:0] DSC_DEN_HI    = 8'h24;
  localparam logic [7:0] DSC_STATUS    = 8'h28;
  localparam logic [7:0] DSC_EFF_LO    = 8'h2C;
  localparam logic [7:0] DSC_EFF_HI    = 8'h30;
  localparam logic [7:0] DSC_APLL_LO   = 8'h34;
  localparam logic [7:0] DSC_APLL_HI   = 8'h38;
  // Control register bit positions
  localparam int CTL_HIST_EN  = 0;
  localparam int CTL_DCO_EN   = 1;
  localparam int CTL_PIN_MODE = 2;
  localparam int CTL_SOFT_RST = 3;
  // Step control register bit positions
  localparam int STP_SOFT_BIT = 0;
  localparam int STP_TRIG_SEL = 4;
  localparam int STP_DIR_SEL  = 6;
  // Timing
  localparam int CLK_MHZ        = 50;
  localparam int CAL_TIME_US    = 10;
  localparam int CAL_CYCLES     = CAL_TIME_US * CLK_MHZ;
  localparam int ACQ_TIME_US    = 20;
  localparam int ACQ_CYCLES     = ACQ_TIME_US * CLK_MHZ;
  localparam int HIST_TIME_US   = 40;
  localparam int HIST_CYCLES    = HIST_TIME_US * CLK_MHZ;
  // Widths and reset values
  localparam int NUM_W  = 40;
  localparam int STEP_W = 38;
  localparam logic [39:0] NUM_RST = 40'h00_0000_0000;
  localparam logic [40:0] DEN_FULL = 41'h100_0000_0000;

  // Operating states, one-hot
  typedef enum logic [4:0] {
    DSC_ST_CAL     = 5'h01,
    DSC_ST_FREERUN = 5'h02,
    DSC_ST_ACQ     = 5'h04,
    DSC_ST_LOCKED  = 5'h08,
    DSC_ST_HOLD    = 5'h10
  } dsc_state_t;

  // Status bundle shown to software and pins
  typedef struct packed {
    logic freq_lock_lost_flag;
    logic phase_lock_lost_flag;
    logic hist_valid;
    logic wide_bw;
    logic apll_locked;
    logic refs_qualified;
  } dsc_status_t;

  // Wishbone slave answer bundle
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dsc_wb_rsp_t;
endpackage

/* File: dv/dsc_dpll_ctrl_props.sv */
`timescale 1ns/1ps
module dsc_dpll_ctrl_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Loop
  input wire logic        xo_valid_i,
  input wire logic [40:0] den_eff_o,
  input wire logic        vco_cal_o,
  input wire logic        ref_qual_en_o,
  input wire logic        wide_bw_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Request pending, then a one-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_next: assert property (s_req |=> s_answer)
    else $error("bus request not answered in one cycle");
  chk_ack_spur: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack without a request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_den_range: assert property (
    den_eff_o != 41'h0 && den_eff_o <= 41'h100_0000_0000)
    else $error("effective denominator out of range");
  chk_cal_start: assert property ($rose(arst_n_i) |-> vco_cal_o)
    else $error("no calibration after reset");
  chk_cal_xo: assert property (vco_cal_o && !xo_valid_i |=> vco_cal_o)
    else $error("calibration ended without crystal");
  chk_cal_noqual: assert property (
    vco_cal_o |-> !ref_qual_en_o && !wide_bw_o)
    else $error("inputs qualified during calibration");
  chk_acq_qual: assert property (wide_bw_o |-> ref_qual_en_o)
    else $error("wide bandwidth without qualified input");
endmodule

bind dsc_dpll_ctrl dsc_dpll_ctrl_props i_props (
  .clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
  .xo_valid_i, .den_eff_o, .vco_cal_o, .ref_qual_en_o, .wide_bw_o);

/* File: dv/dsc_ref_model.sv */
`timescale 1ns/1ps
module dsc_ref_model #(
  parameter logic [39:0] HIST_WORD = 40'h00_0000_0100
) (
  // Clock and scenario controls
  input  wire logic        clk_i,
  input  wire logic        xo_on_i,
  input  wire logic        ref_on_i,
  // Reference and detector levels
  output logic             xo_valid_o,
  output logic [3:0]       ref_valid_o,
  output logic             freq_lock_o,
  output logic             phase_lock_o,
  output logic [39:0]      hist_avg_o,
  // Step pins: trigger bit 1, direction bit 2
  output logic [3:0]       gpio_o
);
  logic [2:0] lock_dly;
  initial begin
    {xo_valid_o, ref_valid_o, freq_lock_o, phase_lock_o} = 7'h00;
    hist_avg_o = HIST_WORD;
    gpio_o = 4'h9;
    lock_dly = 3'h0;
  end
  // Detectors report lock a few cycles after the input shows up
  always @(posedge clk_i) begin
    xo_valid_o <= xo_on_i;
    ref_valid_o <= {3'h0, ref_on_i};
    lock_dly <= {lock_dly[1:0], ref_on_i};
    freq_lock_o <= lock_dly[2] & ref_on_i;
    phase_lock_o <= lock_dly[2] & ref_on_i;
  end
  // Unused pins toggle so a wrong select shows up
  always @(posedge clk_i) begin
    gpio_o[0] <= ~gpio_o[0];
    gpio_o[3] <= ~gpio_o[3];
  end
  // High 120 ns, period 240 ns; direction set a cycle early
  task automatic pulse(input logic down);
    gpio_o[2] <= down;
    @(posedge clk_i);
    gpio_o[1] <= 1'b1;
    repeat (6) @(posedge clk_i);
    gpio_o[1] <= 1'b0;
    gpio_o[2] <= ~down;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

/* File: dv/dsc_dpll_ctrl_tb.sv */
`timescale 1ns/1ps
module dsc_dpll_ctrl_tb;
  typedef struct packed {
    logic [31:0] m;
    logic [31:0] v;
  } dsc_exp_t;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [39:0] dpll_num, apll_num;
  logic        h_acc, f_lost, p_lost;
  logic [31:0] wb_dat = 32'h0;
  logic        xo_on = 1'b0;
  logic        ref_on = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, xo_v, f_lk, p_lk, wide_bw_o, qual, vco_cal_o;
  logic [3:0]  ref_v, gpio;
  logic [39:0] hist, num;
  logic [40:0] den_eff_o;
  logic [37:0] stp;
  int          fail_count = 0;
  int          checked = 0;
  dsc_exp_t    exp_q[$];
  dsc_exp_t    e;

  always #10 clk_i = ~clk_i;

  dsc_dpll_ctrl #(.CAL_CYC(16), .ACQ_CYC(4), .HIST_CYC(8)) i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .xo_valid_i(xo_v), .ref_valid_i(ref_v),
    .freq_lock_i(f_lk), .phase_lock_i(p_lk), .hist_avg_i(hist),
    .gpio_i(gpio), .dpll_num_o(dpll_num), .apll_num_o(apll_num),
    .den_eff_o(den_eff_o), .wide_bw_o(wide_bw_o),
    .ref_qual_en_o(qual), .hist_accum_o(h_acc), .vco_cal_o(vco_cal_o),
    .freq_lock_lost_o(f_lost), .phase_lock_lost_o(p_lost));

  dsc_ref_model i_ref (
    .clk_i(clk_i), .xo_on_i(xo_on), .ref_on_i(ref_on),
    .xo_valid_o(xo_v), .ref_valid_o(ref_v), .freq_lock_o(f_lk),
    .phase_lock_o(p_lk), .hist_avg_o(hist), .gpio_o(gpio));

  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; a read notes its expected data for the monitor
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] m);
    if (!we) exp_q.push_back({m, d & m});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_sel <= 4'hF;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= we ? d : 32'h0;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr40(input logic [7:0] a, input logic [39:0] v);
    wb(1'b1, a, v[31:0], 32'h0);
    wb(1'b1, a + 8'h04, {24'h0, v[39:32]}, 32'h0);
  endtask

  task automatic rd40(input logic [7:0] a, input logic [39:0] v);
    wb(1'b0, a, v[31:0], 32'hFFFF_FFFF);
    wb(1'b0, a + 8'h04, {24'h0, v[39:32]}, 32'hFFFF_FFFF);
  endtask

  // Bounded wait for the acquisition bandwidth level
  task automatic wait_bw(input logic want);
    int n;
    n = 0;
    while (wide_bw_o !== want && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check({40'h0, wide_bw_o}, {40'h0, want});
  endtask

  task automatic tdone(input string name);
    $display("test %s finished", name);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Monitor: oldest note against each read answer
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
      e = exp_q.pop_front();
      check({9'h0, wb_dat_o & e.m}, {9'h0, e.v});
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end

  initial begin
    num = $urandom(32'h2852);
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    wb(1'b0, dsc_pkg::DSC_STATUS, {dsc_pkg::DSC_ST_CAL, 8'h80},
       32'h1F91);
    xo_on <= 1'b1;
    repeat (30) @(posedge clk_i);
    wb(1'b0, dsc_pkg::DSC_STATUS, {dsc_pkg::DSC_ST_FREERUN, 8'h01},
       32'h1F91);
    tdone("startup");
    wr40(dsc_pkg::DSC_DEN_LO, 40'h0);
    @(negedge clk_i);
    check(den_eff_o, dsc_pkg::DEN_FULL);
    @(posedge clk_i);
    wb(1'b1, dsc_pkg::DSC_DEN_LO, 32'h5, 32'h0);
    @(negedge clk_i);
    check(den_eff_o, 41'h5);
    @(posedge clk_i);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF, 32'h0);
    wb(1'b0, 8'h3C, 32'h0, 32'hFFFF_FFFF);
    tdone("registers");
    // Enable refused before lock
    wb(1'b1, dsc_pkg::DSC_CTRL, 32'h3, 32'h0);
    wb(1'b0, dsc_pkg::DSC_CTRL, 32'h1, 32'h3);
    ref_on <= 1'b1;
    wait_bw(1'b1);
    wait_bw(1'b0);
    repeat (5) @(posedge clk_i);
    wb(1'b0, dsc_pkg::DSC_STATUS, {dsc_pkg::DSC_ST_LOCKED, 8'h10},
       32'h1F9E);
    num = {8'($urandom), $urandom};
    stp = {6'($urandom), $urandom};
    wr40(dsc_pkg::DSC_NUM_LO, num);
    wr40(dsc_pkg::DSC_STEP_LO, {2'b00, stp});
    wb(1'b1, dsc_pkg::DSC_CTRL, 32'h3, 32'h0);
    wb(1'b1, dsc_pkg::DSC_STEP_CTL, 32'h90, 32'h0);
    rd40(dsc_pkg::DSC_EFF_LO, num + stp);
    wb(1'b1, dsc_pkg::DSC_STEP_CTL, 32'h91, 32'h0);
    wb(1'b1, dsc_pkg::DSC_STEP_CTL, 32'h91, 32'h0);
    rd40(dsc_pkg::DSC_EFF_LO, num - stp);
    wb(1'b1, dsc_pkg::DSC_CTRL, 32'h7, 32'h0);
    i_ref.pulse(1'b0);
    i_ref.pulse(1'b1);
    i_ref.pulse(1'b1);
    rd40(dsc_pkg::DSC_EFF_LO, num - {stp, 1'b0});
    num = {8'($urandom), $urandom};
    wr40(dsc_pkg::DSC_NUM_LO, num);
    rd40(dsc_pkg::DSC_EFF_LO, num - {stp, 1'b0});
    wb(1'b1, dsc_pkg::DSC_CTRL, 32'h1, 32'h0);
    i_ref.pulse(1'b0);
    rd40(dsc_pkg::DSC_EFF_LO, num);
    check({1'b0, dpll_num}, {1'b0, num});
    tdone("steering");
    wb(1'b0, dsc_pkg::DSC_STATUS, 32'h20, 32'h20);
    check({40'h0, h_acc}, 41'h1);
    ref_on <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, dsc_pkg::DSC_STATUS, {dsc_pkg::DSC_ST_HOLD, 8'h04},
       32'h1F06);
    check({39'h0, p_lost, f_lost}, 41'h2);
    check({1'b0, apll_num}, {1'b0, num + 40'h00_0000_0100});
    rd40(dsc_pkg::DSC_APLL_LO, num + 40'h00_0000_0100);
    ref_on <= 1'b1;
    wait_bw(1'b1);
    wait_bw(1'b0);
    tdone("holdover");
    // Soft reset write with bit 0 low clears history enable too
    wb(1'b1, dsc_pkg::DSC_CTRL, 32'h8, 32'h0);
    @(negedge clk_i);
    check({40'h0, vco_cal_o}, 41'h1);
    @(posedge clk_i);
    wait_bw(1'b1);
    wait_bw(1'b0);
    repeat (3) @(posedge clk_i);
    ref_on <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, dsc_pkg::DSC_STATUS, {dsc_pkg::DSC_ST_FREERUN, 8'h01},
       32'h1F91);
    wr40(dsc_pkg::DSC_NUM_LO, num);
    wr40(dsc_pkg::DSC_OFS_LO, 40'hFF_FFFF_FFFB);
    rd40(dsc_pkg::DSC_APLL_LO, num - 40'h5);
    tdone("freerun");
    report_and_stop();
  end
endmodule
